/* inc/eirp_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types of the serial memory target
// Assumes: 20 MHz reference clock, 2048 x 8 array
// Notes:   Write cycle time is a plain default, tune per process
//////////////////////////////////////////////////////////////////////////////
package eirp_pkg;
   localparam int ADDR_W        = 11;
   localparam int DATA_W        = 8;
   localparam int MEM_WORDS     = 2048;
   localparam int FIFO_DEPTH    = 32;
   localparam int FIFO_W        = ADDR_W + DATA_W;

   // Frame field positions
   localparam int CODE_MSB      = 7;
   localparam int CODE_LSB      = 4;
   localparam int BLK_MSB       = 3;
   localparam int BLK_LSB       = 1;
   localparam int RW_BIT        = 0;
   localparam int ADDR_BLK_LSB  = 8;
   localparam int ADDR_NIB      = 4;

   localparam logic [3:0] DEV_CODE   = 4'hA;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam logic [3:0] LAST_RISE  = 4'h7;
   localparam logic [3:0] NIB_ONE    = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;

   // Link synchroniser reset image: scl, sda, lowSupply, clkEn, done toggle
   localparam logic [4:0] LINK_SYNC_INIT = 5'h18;

   // Write cycle timing
   localparam int REF_PERIOD_NS = 50;
   localparam int WRITE_TIME_NS = 5000;
   localparam int WRITE_CYCLES  = (WRITE_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int WR_CNT_W      = 8;
   localparam logic [WR_CNT_W-1:0] WRITE_LOAD = WR_CNT_W'(WRITE_CYCLES - 1);
   localparam logic [WR_CNT_W-1:0] WR_CNT_ONE = 8'h01;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DEVADDR,
      ST_DEVACK,
      ST_WORDADDR,
      ST_WORDACK,
      ST_WDATA,
      ST_WDACK,
      ST_RDATA,
      ST_RDACK
   } eirp_state_e;
endpackage

/* core/eirp_sync.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   Output moves only when stages two and three agree
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module eirp_sync
#(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input  wire logic         clk,
   input  wire logic         rstN,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1Reg;
   logic [W-1:0] s2Reg;
   logic [W-1:0] s3Reg;
   logic [W-1:0] qReg;
   logic [W-1:0] agree;
   logic [W-1:0] qNext;

   assign agree = ~(s2Reg ^ s3Reg);
   assign qNext = (agree & s3Reg) | (~agree & qReg);
   assign q     = qReg;

   always_ff @(posedge clk)
   begin
      if (!rstN)
      begin
         s1Reg <= INIT;
         s2Reg <= INIT;
         s3Reg <= INIT;
         qReg  <= INIT;
      end
      else
      begin
         s1Reg <= d;
         s2Reg <= s1Reg;
         s3Reg <= s2Reg;
         qReg  <= qNext;
      end
   end
endmodule

/* core/eirp_fifo.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Single-clock FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Flush empties it in one cycle
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module eirp_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input  wire logic             clk,
   input  wire logic             rstN,
   input  wire logic             en,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] memArr [DEPTH];
   logic [PW-1:0]    wrPtrReg;
   logic [PW-1:0]    rdPtrReg;
   logic [PW:0]      countReg;
   logic             pushFire;
   logic             popFire;

   assign inReady  = countReg != (PW+1)'(DEPTH);
   assign outValid = countReg != '0;
   assign pushFire = inValid & inReady & en;
   assign popFire  = outValid & outReady & en;
   assign outData  = memArr[rdPtrReg];

   always_ff @(posedge clk)
   begin
      if (pushFire)
         memArr[wrPtrReg] <= inData;
   end

   always_ff @(posedge clk)
   begin
      if (!rstN || (en && flush))
      begin
         wrPtrReg <= '0;
         rdPtrReg <= '0;
         countReg <= '0;
      end
      else
      begin
         wrPtrReg <= wrPtrReg + PW'(pushFire);
         rdPtrReg <= rdPtrReg + PW'(popFire);
         countReg <= countReg + (PW+1)'(pushFire) - (PW+1)'(popFire);
      end
   end
endmodule

/* core/eirp_core.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-wire serial memory target: polling, reads, page buffering
// Assumes: linkClk oversamples SCL/SDA well above the bus rate
// Notes:   Write cycle timer runs on ref_clk, protocol on linkClk
//////////////////////////////////////////////////////////////////////////////
// What this block does
// [RL1] Once a write cycle starts, ignore the bus and never acknowledge until done.
// [RL2] Polling frame: no acknowledge while busy, acknowledge once the cycle ends.
// [RL3] Master should poll with the read direction bit.
// [RL4] After a polling acknowledge the same transaction continues as write or read.
// [RL5] Master never starts while data is driven; it waits, stops, then commands.
// [RL6] Address counter keeps the last accessed address plus one after reads and writes.
// [RL7] Matching read frame is acknowledged, byte n shifted out, counter becomes n+1.
// [RL8] Master ends a read with no acknowledge and a stop.
// [RL9] Reads increment the full counter after the eighth bit leaves.
// [RL10] Writes advance only the low nibble; upper bits stay.
// [RL11] Dummy write: acknowledge frame and word address, load counter, no data needed.
// [RL12] Random read is dummy write, repeated start, then a current read.
// [RL13] Master acknowledge makes the next address byte follow.
// [RL14] Counter wraps from the last word address to the first.
// [RL15] Low supply flagged at stop aborts the pending write.
// [RL16] Only frames whose top four bits equal the type code are answered.
// [RL17] Three bits after the code in a write frame select one of eight 256-byte blocks.
// [RL18] Bytes of eight bits; the receiver pulls SDA low in the ninth clock.
// [RL19] Counter is eleven bits, block select on top.
`timescale 1ns/1ps
module eirp_core
   import eirp_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic clkEn,
   input  wire logic linkClk,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   input  wire logic lowSupplyIn,
   output logic      writeBusy
);
   ///////////////////////////////////////////////////////////////////////////
   // Crossings
   logic              linkRstN;
   logic [4:0]        linkRaw;
   logic [4:0]        linkStable;
   logic              doneTglReg;
   logic              reqTglReg;
   logic              reqS;
   logic              sclS;
   logic              sdaS;
   logic              lowS;
   logic              linkEn;
   logic              doneS;

   eirp_sync #(.W(1), .INIT(1'b0)) uRstSync
   (
      .clk  (linkClk),
      .rstN (1'b1),
      .d    (rst_n),
      .q    (linkRstN)
   );

   assign linkRaw = {sclIn, sdaIn, lowSupplyIn, clkEn, doneTglReg};

   eirp_sync #(.W(5), .INIT(LINK_SYNC_INIT)) uLinkSync
   (
      .clk  (linkClk),
      .rstN (linkRstN),
      .d    (linkRaw),
      .q    (linkStable)
   );

   eirp_sync #(.W(1), .INIT(1'b0)) uReqSync
   (
      .clk  (ref_clk),
      .rstN (rst_n),
      .d    (reqTglReg),
      .q    (reqS)
   );

   assign sclS   = linkStable[4];
   assign sdaS   = linkStable[3];
   assign lowS   = linkStable[2];
   assign linkEn = linkStable[1];
   assign doneS  = linkStable[0];

   ///////////////////////////////////////////////////////////////////////////
   // Bus events
   logic              sclQReg;
   logic              sdaQReg;
   logic              sclRise;
   logic              sclFall;
   logic              startDet;
   logic              stopDet;

   assign sclRise  = sclS & ~sclQReg;
   assign sclFall  = ~sclS & sclQReg;
   assign startDet = sclS & sclQReg & sdaQReg & ~sdaS;
   assign stopDet  = sclS & sclQReg & ~sdaQReg & sdaS;

   ///////////////////////////////////////////////////////////////////////////
   // Protocol decode
   eirp_state_e       stateReg;
   eirp_state_e       stateNext;
   logic [3:0]        bitCntReg;
   logic [7:0]        shiftReg;
   logic [7:0]        txReg;
   logic [ADDR_W-1:0] addrCntReg;
   logic              rwReg;
   logic              mAckReg;
   logic              sdaLowReg;
   logic              wrPendReg;
   logic              busyReg;
   logic              doneSeenReg;
   logic [DATA_W-1:0] memArr [MEM_WORDS];
   logic [DATA_W-1:0] rdByte;
   logic              byteDone;
   logic              rxState;
   logic              devMatch;
   logic              devAck;
   logic              wordAck;
   logic              pushData;
   logic              ackEnd;
   logic              rdLoad;
   logic              rdShift;
   logic              rdIncr;
   logic              rdRelease;
   logic              launchWr;
   logic              abortWr;
   logic              fifoFlush;
   logic              fifoInReady;
   logic              fifoOutValid;
   logic [FIFO_W-1:0] fifoOutData;
   logic              popFire;
   logic              writeDone;

   assign rdByte    = memArr[addrCntReg];
   assign byteDone  = (bitCntReg == BYTE_BITS) && sclFall;
   assign rxState   = (stateReg == ST_DEVADDR) || (stateReg == ST_WORDADDR)
                   || (stateReg == ST_WDATA);
   assign devMatch  = shiftReg[CODE_MSB:CODE_LSB] == DEV_CODE;  // RL16
   assign devAck    = (stateReg == ST_DEVADDR) && byteDone && devMatch;
   assign wordAck   = (stateReg == ST_WORDADDR) && byteDone;
   // No room in the page buffer means no acknowledge
   assign pushData  = (stateReg == ST_WDATA) && byteDone && fifoInReady;
   assign ackEnd    = ((stateReg == ST_DEVACK) || (stateReg == ST_WORDACK)
                   || (stateReg == ST_WDACK)) && sclFall;
   assign rdLoad    = sclFall && (((stateReg == ST_DEVACK) && rwReg)
                   || ((stateReg == ST_RDACK) && mAckReg));  // RL7 RL13
   assign rdShift   = (stateReg == ST_RDATA) && sclFall && (bitCntReg != BYTE_BITS);
   assign rdIncr    = (stateReg == ST_RDATA) && sclRise && (bitCntReg == LAST_RISE);
   assign rdRelease = (stateReg == ST_RDATA) && byteDone;
   assign launchWr  = stopDet && wrPendReg && !lowS;
   assign abortWr   = stopDet && wrPendReg && lowS;  // RL15
   // A start in mid-write cancels the buffered bytes
   assign fifoFlush = abortWr || (startDet && wrPendReg && !busyReg);
   assign popFire   = fifoOutValid && busyReg;
   assign writeDone = busyReg && (doneS != doneSeenReg) && !fifoOutValid;
   assign sdaOut    = 1'b0;
   assign sdaOe     = sdaLowReg;

   always_comb
   begin
      stateNext = stateReg;
      if (startDet && !busyReg)
         stateNext = ST_DEVADDR;  // RL1 RL2
      else if (stopDet)
         stateNext = ST_IDLE;
      else
      begin
         unique case (stateReg)
            ST_IDLE:     stateNext = ST_IDLE;
            ST_DEVADDR:  if (byteDone) stateNext = devMatch ? ST_DEVACK : ST_IDLE;
            ST_DEVACK:   if (sclFall) stateNext = rwReg ? ST_RDATA : ST_WORDADDR;  // RL4
            ST_WORDADDR: if (byteDone) stateNext = ST_WORDACK;
            ST_WORDACK:  if (sclFall) stateNext = ST_WDATA;
            ST_WDATA:    if (byteDone) stateNext = fifoInReady ? ST_WDACK : ST_IDLE;
            ST_WDACK:    if (sclFall) stateNext = ST_WDATA;
            ST_RDATA:    if (byteDone) stateNext = ST_RDACK;
            ST_RDACK:    if (sclFall) stateNext = mAckReg ? ST_RDATA : ST_IDLE;  // RL13
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Link state
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         sclQReg  <= 1'b1;
         sdaQReg  <= 1'b1;
         stateReg <= ST_IDLE;
      end
      else if (linkEn)
      begin
         sclQReg  <= sclS;
         sdaQReg  <= sdaS;
         stateReg <= stateNext;
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
         bitCntReg <= '0;
      else if (linkEn)
      begin
         if (startDet || ackEnd || rdLoad)
            bitCntReg <= '0;
         else if (sclRise && (rxState || (stateReg == ST_RDATA)))
            bitCntReg <= bitCntReg + NIB_ONE;  // RL18
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         shiftReg <= '0;
         rwReg    <= 1'b0;
         mAckReg  <= 1'b0;
      end
      else if (linkEn)
      begin
         if (sclRise && rxState)
            shiftReg <= {shiftReg[6:0], sdaS};
         if (devAck)
            rwReg <= shiftReg[RW_BIT];
         if ((stateReg == ST_RDACK) && sclRise)
            mAckReg <= ~sdaS;
      end
   end

   // Counter held across transactions
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
         addrCntReg <= '0;
      else if (linkEn)
      begin
         if (devAck && !shiftReg[RW_BIT])
            addrCntReg[ADDR_W-1:ADDR_BLK_LSB] <= shiftReg[BLK_MSB:BLK_LSB];  // RL17 RL19
         else if (wordAck)
            addrCntReg[ADDR_BLK_LSB-1:0] <= shiftReg;  // RL11
         else if (pushData)
            addrCntReg[ADDR_NIB-1:0] <= addrCntReg[ADDR_NIB-1:0] + NIB_ONE;  // RL10
         else if (rdIncr)
            addrCntReg <= addrCntReg + ADDR_ONE;  // RL9 RL14 RL6
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         txReg     <= '0;
         sdaLowReg <= 1'b0;
      end
      else if (linkEn)
      begin
         if (devAck || wordAck || pushData)
            sdaLowReg <= 1'b1;  // RL18 RL2
         else if (rdLoad)
         begin
            txReg     <= rdByte;
            sdaLowReg <= ~rdByte[7];  // RL7
         end
         else if (rdShift)
         begin
            txReg     <= {txReg[6:0], 1'b0};
            sdaLowReg <= ~txReg[6];
         end
         else if (ackEnd || rdRelease || stopDet)
            sdaLowReg <= 1'b0;
      end
   end

   // Busy gate: toggle request out, toggle done back
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         wrPendReg   <= 1'b0;
         busyReg     <= 1'b0;
         reqTglReg   <= 1'b0;
         doneSeenReg <= 1'b0;
      end
      else if (linkEn)
      begin
         if (pushData)
            wrPendReg <= 1'b1;
         else if (stopDet || startDet)
            wrPendReg <= 1'b0;
         if (launchWr)
         begin
            busyReg   <= 1'b1;  // RL1
            reqTglReg <= ~reqTglReg;
         end
         else if (writeDone)
         begin
            busyReg     <= 1'b0;
            doneSeenReg <= doneS;
         end
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (linkEn && popFire)
         memArr[fifoOutData[FIFO_W-1:DATA_W]] <= fifoOutData[DATA_W-1:0];
   end

   // Page buffer; drains only during the write cycle
   eirp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) uPageBuf
   (
      .clk      (linkClk),
      .rstN     (linkRstN),
      .en       (linkEn),
      .flush    (fifoFlush),
      .inValid  (pushData),
      .inReady  (fifoInReady),
      .inData   ({addrCntReg, shiftReg}),
      .outValid (fifoOutValid),
      .outReady (busyReg),
      .outData  (fifoOutData)
   );

   ///////////////////////////////////////////////////////////////////////////
   // Write cycle timer
   logic                reqSeenReg;
   logic                wrRunReg;
   logic [WR_CNT_W-1:0] wrCntReg;

   assign writeBusy = wrRunReg;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         reqSeenReg <= 1'b0;
         wrRunReg   <= 1'b0;
         wrCntReg   <= '0;
         doneTglReg <= 1'b0;
      end
      else if (clkEn)
      begin
         if (reqS != reqSeenReg)
         begin
            reqSeenReg <= reqS;
            wrRunReg   <= 1'b1;
            wrCntReg   <= WRITE_LOAD;
         end
         else if (wrRunReg && (wrCntReg == '0))
         begin
            wrRunReg   <= 1'b0;
            doneTglReg <= ~doneTglReg;
         end
         else if (wrRunReg)
            wrCntReg <= wrCntReg - WR_CNT_ONE;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Checks
   chk_busy_no_ack: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL1
      busyReg && linkEn |=> !sdaOe)
      else $error("Acknowledge driven during write cycle");

   chk_code_match: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL16
      (stateReg == ST_DEVACK) |-> shiftReg[CODE_MSB:CODE_LSB] == DEV_CODE)
      else $error("Frame with wrong type code accepted");

   chk_ack_edge: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL18
      $rose(sdaOe) |-> $past(sclFall))
      else $error("SDA pulled low away from SCL fall");

   chk_read_incr: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL9
      linkEn && rdIncr |=> addrCntReg == $past(addrCntReg) + ADDR_ONE)
      else $error("Read did not advance counter");

   chk_write_nibble: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL10
      linkEn && pushData
      |=> (addrCntReg[ADDR_W-1:ADDR_NIB] == $past(addrCntReg[ADDR_W-1:ADDR_NIB]))
      && (addrCntReg[ADDR_NIB-1:0] == $past(addrCntReg[ADDR_NIB-1:0]) + NIB_ONE))
      else $error("Write changed upper address bits");

   chk_word_load: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL11
      linkEn && wordAck |=> addrCntReg[ADDR_BLK_LSB-1:0] == $past(shiftReg))
      else $error("Word address not loaded");

   chk_block_load: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL17
      linkEn && devAck && !shiftReg[RW_BIT]
      |=> addrCntReg[ADDR_W-1:ADDR_BLK_LSB] == $past(shiftReg[BLK_MSB:BLK_LSB]))
      else $error("Block select not loaded");

   chk_low_abort: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL15
      linkEn && abortWr |=> !busyReg ##1 !fifoOutValid)
      else $error("Write started under low supply");

   chk_idle_hold: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL6
      linkEn && (stateReg == ST_IDLE) && !startDet |=> $stable(addrCntReg))
      else $error("Counter moved while idle");

   chk_seq_next: assert property (@(posedge linkClk) disable iff (!linkRstN)  // RL13
      linkEn && (stateReg == ST_RDACK) && sclFall && mAckReg
      |=> (stateReg == ST_RDATA) && (txReg == $past(rdByte)))
      else $error("Next byte not loaded after master acknowledge");

   chk_write_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RL1
      $rose(wrRunReg) |-> wrRunReg [*8])
      else $error("Write cycle ended too early");
endmodule

/* testbench/eirp_master.sv */
// Purpose: Two-wire bus master model for the serial memory target
// Assumes: SDA pulled up; bit timing counted in linkClk cycles
// Notes:   SCL stands high between frames
`timescale 1ns/1ps
module eirp_master
(
   input  wire logic linkClk,
   input  wire logic sdaWire,
   output logic      sclOut,
   output logic      sdaLow
);
   initial
   begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic waitLk(input int n);
      repeat (n) @(posedge linkClk);
   endtask
   // Also serves as repeated start
   task automatic startBit();
      waitLk(4);
      sdaLow <= 1'b0;
      waitLk(8);
      sclOut <= 1'b1;
      waitLk(12);
      sdaLow <= 1'b1;
      waitLk(12);
      sclOut <= 1'b0;
   endtask
   task automatic stopBit();
      waitLk(4);
      sdaLow <= 1'b1;
      waitLk(8);
      sclOut <= 1'b1;
      waitLk(12);
      sdaLow <= 1'b0;
      waitLk(12);
   endtask
   // Sample off the edge the target updates on
   task automatic clockBit(input logic low, output logic seen);
      waitLk(4);
      sdaLow <= low;
      waitLk(8);
      sclOut <= 1'b1;
      waitLk(6);
      @(negedge linkClk) seen = sdaWire;
      waitLk(6);
      sclOut <= 1'b0;
   endtask
   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clockBit(!b[i], s);
      clockBit(1'b0, s);
      ack = !s;
   endtask
   // Ack slot always completes before any stop or start
   task automatic readByte(input logic mAck, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         clockBit(1'b0, s);
         d[i] = s;
      end
      clockBit(mAck, s);
   endtask
endmodule

/* testbench/tb.sv */
// Purpose: Self-checking bench for the serial memory target
// Assumes: Master model on the bus, pull-up on SDA
// Notes:   Write cycle is shorter than one poll frame
`timescale 1ns/1ps
module tb
   import eirp_pkg::*;
;
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } eirp_row_s;
   logic       ref_clk     = 1'b0;
   logic       linkClk     = 1'b0;
   logic       rst_n       = 1'b0;
   logic       clkEn       = 1'b1;
   logic       lowSupplyIn = 1'b0;
   logic       sclOut;
   logic       sdaLow;
   logic       sdaOut;
   logic       sdaOe;
   logic       writeBusy;
   wire        sdaWire     = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
   int         miscompares = 0;
   int         nCompared   = 0;
   logic [7:0] rd;
   eirp_row_s  rows [4]    = '{'{11'h7FF, 8'hC3}, '{11'h000, 8'h5A},
                               '{11'h001, 8'h96}, '{11'h35A, 8'h3C}};
   eirp_core i_eirp_core
   (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .clkEn       (clkEn),
      .linkClk     (linkClk),
      .sclIn       (sclOut),
      .sdaIn       (sdaWire),
      .sdaOut      (sdaOut),
      .sdaOe       (sdaOe),
      .lowSupplyIn (lowSupplyIn),
      .writeBusy   (writeBusy)
   );
   eirp_master i_eirp_master
   (
      .linkClk (linkClk),
      .sdaWire (sdaWire),
      .sclOut  (sclOut),
      .sdaLow  (sdaLow)
   );
   always #25 ref_clk = ~ref_clk;
   always #16 linkClk = ~linkClk;
   //////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] dev(input logic [10:0] a, input logic rw);
      return {DEV_CODE, a[10:8], rw};
   endfunction
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tx(input logic [7:0] b, input logic expAck, input string what);
      logic ack;
      i_eirp_master.sendByte(b, ack);
      chk(what, {7'h00, ack}, {7'h00, expAck});
   endtask
   task automatic rx(input logic mAck, input logic [7:0] exp, input string what);
      i_eirp_master.readByte(mAck, rd);
      chk(what, rd, exp);
   endtask
   task automatic busyChk(input logic exp);
      i_eirp_master.waitLk(20);
      chk("write busy", {7'h00, writeBusy}, {7'h00, exp});
   endtask
   task automatic wrSeq(input logic [10:0] a, input logic [7:0] base, input int n,
                        input logic fresh);
      if (fresh)
      begin
         i_eirp_master.startBit();
         tx(dev(a, 1'b0), 1'b1, "write frame");
      end
      tx(a[7:0], 1'b1, "word address");
      for (int i = 0; i < n; i++)
         tx(base + 8'(i), 1'b1, "write data");
      i_eirp_master.stopBit();
   endtask
   task automatic rdFrom(input logic [10:0] a, input logic dummy);
      i_eirp_master.startBit();
      if (dummy)
      begin
         tx(dev(a, 1'b0), 1'b1, "dummy frame");
         tx(a[7:0], 1'b1, "dummy address");
         i_eirp_master.startBit();
      end
      tx(dev(a, 1'b1), 1'b1, "read frame");
   endtask
   // Bounded retries; write-direction poll leaves the frame open
   task automatic poll(input logic [10:0] a, input logic rw);
      logic ack;
      ack = 1'b0;
      for (int k = 0; k < 20 && !ack; k++)
      begin
         i_eirp_master.startBit();
         i_eirp_master.sendByte(dev(a, rw), ack);
         if (!ack)
            i_eirp_master.stopBit();
      end
      chk("poll ack", {7'h00, ack}, 8'h01);
      if (rw)
      begin
         i_eirp_master.readByte(1'b0, rd);
         i_eirp_master.stopBit();
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && nCompared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   initial
   begin
      #4_000_000;
      miscompares++;
      summarize();
   end
   initial
   begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("reset sda drive", {7'h00, sdaOe}, 8'h00);
      chk("reset busy", {7'h00, writeBusy}, 8'h00);
      @(posedge ref_clk) rst_n <= 1'b1;
      i_eirp_master.waitLk(10);
      foreach (rows[r])
      begin
         wrSeq(rows[r].addr, rows[r].data, 1, 1'b1);
         busyChk(1'b1);
         i_eirp_master.startBit();
         tx(dev(rows[r].addr, 1'b1), 1'b0, "poll while busy");
         i_eirp_master.stopBit();
         poll(rows[r].addr, 1'b1);
         rdFrom(rows[r].addr, 1'b1);
         rx(1'b0, rows[r].data, "random read");
         i_eirp_master.stopBit();
      end
      // Wrap past the last word, then current read
      rdFrom(11'h7FF, 1'b1);
      rx(1'b1, 8'hC3, "last word");
      rx(1'b0, 8'h5A, "wrapped word");
      i_eirp_master.stopBit();
      rdFrom(11'h000, 1'b0);
      rx(1'b0, 8'h96, "current read");
      i_eirp_master.stopBit();
      // Dummy write alone starts no cycle
      wrSeq(11'h000, 8'h00, 0, 1'b1);
      busyChk(1'b0);
      rdFrom(11'h000, 1'b0);
      rx(1'b0, 8'h5A, "loaded address");
      i_eirp_master.stopBit();
      i_eirp_master.startBit();
      tx(8'hB1, 1'b0, "foreign code");
      i_eirp_master.stopBit();
      // Frozen target must not answer
      @(posedge ref_clk) clkEn <= 1'b0;
      i_eirp_master.startBit();
      tx(dev(11'h000, 1'b1), 1'b0, "frozen frame");
      i_eirp_master.stopBit();
      @(posedge ref_clk) clkEn <= 1'b1;
      @(posedge ref_clk) lowSupplyIn <= 1'b1;
      wrSeq(11'h35A, 8'hE1, 1, 1'b1);
      busyChk(1'b0);
      @(posedge ref_clk) lowSupplyIn <= 1'b0;
      rdFrom(11'h35A, 1'b1);
      rx(1'b0, 8'h3C, "aborted write");
      i_eirp_master.stopBit();
      // Page write carried on from a polling frame
      wrSeq(11'h100, 8'h11, 1, 1'b1);
      poll(11'h500, 1'b0);
      wrSeq(11'h54F, 8'h70, 3, 1'b0);
      poll(11'h000, 1'b1);
      rdFrom(11'h54F, 1'b1);
      rx(1'b0, 8'h70, "page first");
      i_eirp_master.stopBit();
      rdFrom(11'h540, 1'b1);
      rx(1'b1, 8'h71, "page rolled");
      rx(1'b0, 8'h72, "page next");
      i_eirp_master.stopBit();
      // Second reset: counter back to zero, array kept
      @(posedge ref_clk) rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("mid reset busy", {7'h00, writeBusy}, 8'h00);
      @(posedge ref_clk) rst_n <= 1'b1;
      i_eirp_master.waitLk(10);
      rdFrom(11'h000, 1'b0);
      rx(1'b0, 8'h5A, "counter after reset");
      i_eirp_master.stopBit();
      summarize();
   end
endmodule
